// ### common/twm_regs.vh
/*
 two-wire master receiver: shared constants.
 assumes inclusion by the core files; definitions only.
*/
`ifndef TWM_REGS_VH
`define TWM_REGS_VH

// timing
`define TWM_CLK_NS        40
`define TWM_HALF_NS       2000
`define TWM_HALF_CYC      8'h32

// byte framing
`define TWM_LAST_BIT      4'h7
`define TWM_ACK_BIT       4'h8

// receive path
`define TWM_DATA_W        8
`define TWM_FIFO_DEPTH    4
`define TWM_FIFO_AW       2

// reset values
`define TWM_LINE_IDLE     1'b1
`define TWM_TRANSFER_COMPLETE_FLAG_RST    1'b1

// internal address sizes
`define TWM_IA_ONE        2'h1
`define TWM_IA_TWO        2'h2
`define TWM_IA_THREE      2'h3

`endif

// ### core/twm_sync.v
/*
 two flip-flop synchroniser for a group of level inputs.
 assumes inputs are asynchronous to clk_i; idle value is high.
*/
`timescale 1ns/10ps
`include "twm_regs.vh"
module twm_sync #(
   parameter W = 2
) (
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= {W{`TWM_LINE_IDLE}};
         sync_q <= {W{`TWM_LINE_IDLE}};
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule

// ### core/twm_fifo.v
/*
 small flip-flop fifo with valid/ready on both sides.
 assumes one clock; depth is a power of two equal to 2**AW.
*/
`timescale 1ns/10ps
`include "twm_regs.vh"
module twm_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;

   assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ### core/twm_master.v
/*
 two-wire bus master: reads with optional internal address, arbitration,
 bus busy watch, receive fifo and holding register.
 assumes open-drain lines with external pull-ups; control bits are
 driven by software logic on clk_i.
*/
`timescale 1ns/10ps
`include "twm_regs.vh"
module twm_master (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        scl_i,
   output wire        scl_o,
   output wire        scl_oe_o,
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe_o,
   input  wire        master_role_on_i,
   input  wire        slave_role_on_i,
   input  wire        start_i,
   input  wire        stop_i,
   input  wire        read_direction_flag_i,
   input  wire [6:0]  device_address_field_i,
   input  wire [1:0]  internal_address_size_i,
   input  wire [23:0] internal_address_bytes_i,
   input  wire        rhr_read_i,
   input  wire        status_read_i,
   input  wire        dma_rx_enable_i,
   input  wire        arb_irq_enable_i,
   output wire [7:0]  receive_holding_register_o,
   output wire        receive_holding_full_o,
   output wire        dma_rx_req_o,
   output wire        no_ack_flag_o,
   output wire        arbitration_lost_flag_o,
   output wire        transfer_complete_flag_o,
   output wire        arb_irq_o,
   output wire        slave_ack_allow_o
);
   localparam [7:0] HALF_CYC = `TWM_HALF_CYC;
   localparam [3:0] ST_IDLE  = 4'h1;
   localparam [3:0] ST_START = 4'h2;
   localparam [3:0] ST_BIT   = 4'h4;
   localparam [3:0] ST_STOP  = 4'h8;

   reg  [3:0]  state_q;
   reg  [1:0]  ph_q;
   reg  [7:0]  cnt_q;
   reg  [3:0]  bit_q;
   reg  [7:0]  shift_q;
   reg  [1:0]  ia_left_q;
   reg         restart_q;
   reg         addr_q;
   reg         rw_q;
   reg         rx_q;
   reg         last_q;
   reg         push_q;
   reg         start_pend_q;
   reg         stop_pend_q;
   reg         busy_q;
   reg         scl_prev_q;
   reg         sda_prev_q;
   reg         no_ack_flag_q;
   reg         arb_q;
   reg         transfer_complete_flag_q;
   reg         irq_q;
   reg         sack_q;
   reg         scl_oe_q;
   reg         sda_oe_q;
   reg  [7:0]  rhr_q;
   reg         rhr_full_q;
   reg         dreq_q;
   reg         scl_low_d;
   reg         sda_low_d;
   reg  [7:0]  ia_byte;
   wire [1:0]  lines_s;
   wire        scl_s;
   wire        sda_s;
   wire        seen_start;
   wire        seen_stop;
   wire        high_ph;
   wire        step;
   wire        wait_push;
   wire        go;
   wire        arb_hit;
   wire        fifo_ready;
   wire        fifo_valid;
   wire [7:0]  fifo_data;
   wire        fifo_pop;
   wire        addr_rw;

   twm_sync #(
      .W (2)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({scl_i, sda_i}),
      .q_o   (lines_s)
   );
   assign scl_s = lines_s[1];
   assign sda_s = lines_s[0];

   // bus condition detection
   assign seen_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign seen_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // busy tracked internally only, no port carries it
   always @(posedge clk_i) begin
      if (rst_i) begin
         scl_prev_q <= `TWM_LINE_IDLE;
         sda_prev_q <= `TWM_LINE_IDLE;
         busy_q     <= 1'b0;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         if (seen_stop) begin
            busy_q <= 1'b0;
         end else if (seen_start) begin
            busy_q <= 1'b1;
         end
      end
   end

   // phase timing, high phases stretch while scl held low
   assign high_ph   = ph_q[0];
   assign step      = (cnt_q == 8'h00) & (~high_ph | scl_s);
   assign wait_push = push_q & (state_q == ST_BIT) & (bit_q == `TWM_ACK_BIT);
   assign go        = step & ~wait_push;
   assign arb_hit   = go & (state_q == ST_BIT) & (ph_q == 2'h1) & ~rx_q
                    & (bit_q <= `TWM_LAST_BIT) & shift_q[7] & ~sda_s;
   assign addr_rw   = (ia_left_q == 2'h0) & read_direction_flag_i;

   always @* begin
      case (ia_left_q)
         `TWM_IA_THREE: ia_byte = internal_address_bytes_i[23:16];
         `TWM_IA_TWO:   ia_byte = internal_address_bytes_i[15:8];
         default:       ia_byte = internal_address_bytes_i[7:0];
      endcase
   end

   // line drive per state and phase
   always @* begin
      scl_low_d = 1'b0;
      sda_low_d = 1'b0;
      case (state_q)
         ST_START: begin
            scl_low_d = (ph_q == 2'h0) & restart_q;
            sda_low_d = (ph_q == 2'h2);
         end
         ST_BIT: begin
            scl_low_d = ~high_ph;
            if (bit_q <= `TWM_LAST_BIT) begin
               sda_low_d = ~rx_q & ~shift_q[7];
            end else begin
               sda_low_d = rx_q & ~last_q;
            end
         end
         ST_STOP: begin
            scl_low_d = (ph_q == 2'h0);
            sda_low_d = (ph_q != 2'h2);
         end
         default: begin
            scl_low_d = 1'b0;
            sda_low_d = 1'b0;
         end
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q      <= ST_IDLE;
         ph_q         <= 2'h0;
         cnt_q        <= 8'h00;
         bit_q        <= 4'h0;
         shift_q      <= 8'h00;
         ia_left_q    <= 2'h0;
         restart_q    <= 1'b0;
         addr_q       <= 1'b0;
         rw_q         <= 1'b0;
         rx_q         <= 1'b0;
         last_q       <= 1'b0;
         push_q       <= 1'b0;
         start_pend_q <= 1'b0;
         stop_pend_q  <= 1'b0;
         no_ack_flag_q       <= 1'b0;
         arb_q        <= 1'b0;
         transfer_complete_flag_q     <= `TWM_TRANSFER_COMPLETE_FLAG_RST;
         scl_oe_q     <= 1'b0;
         sda_oe_q     <= 1'b0;
      end else begin
         scl_oe_q <= scl_low_d;
         sda_oe_q <= sda_low_d & ~arb_hit;
         if (push_q & fifo_ready) begin
            push_q <= 1'b0;
         end
         if (status_read_i) begin
            no_ack_flag_q <= 1'b0;
            arb_q  <= 1'b0;
         end
         if (start_i) begin
            start_pend_q <= 1'b1;
            transfer_complete_flag_q     <= 1'b0;
         end
         if (stop_i) begin
            stop_pend_q <= 1'b1;
         end
         if (cnt_q != 8'h00 && (!high_ph || scl_s)) begin
            cnt_q <= cnt_q - 1'b1;
         end
         if (arb_hit) begin
            arb_q        <= 1'b1;
            start_pend_q <= 1'b0;
            stop_pend_q  <= 1'b0;
            transfer_complete_flag_q     <= 1'b1;
            state_q      <= ST_IDLE;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  // wait for free bus with master enabled
                  if (start_pend_q && master_role_on_i && !busy_q) begin
                     state_q      <= ST_START;
                     start_pend_q <= 1'b0;
                     restart_q    <= 1'b0;
                     ia_left_q    <= internal_address_size_i;
                     ph_q         <= 2'h0;
                     cnt_q        <= HALF_CYC;
                  end
               end
               ST_START: begin
                  if (go) begin
                     cnt_q <= HALF_CYC;
                     if (ph_q == 2'h2) begin
                        state_q <= ST_BIT;
                        ph_q    <= 2'h0;
                        bit_q   <= 4'h0;
                        addr_q  <= 1'b1;
                        rx_q    <= 1'b0;
                        rw_q    <= addr_rw;
                        shift_q <= {device_address_field_i, addr_rw};
                     end else begin
                        ph_q <= ph_q + 1'b1;
                     end
                  end
               end
               ST_BIT: begin
                  if (go) begin
                     cnt_q <= HALF_CYC;
                     if (!high_ph) begin
                        ph_q <= 2'h1;
                     end else if (bit_q <= `TWM_LAST_BIT) begin
                        ph_q  <= 2'h0;
                        bit_q <= bit_q + 1'b1;
                        shift_q <= {shift_q[6:0], sda_s};
                        if (rx_q && bit_q == `TWM_LAST_BIT) begin
                           push_q <= 1'b1;
                           last_q <= stop_pend_q;
                        end
                     end else begin
                        ph_q  <= 2'h0;
                        bit_q <= 4'h0;
                        if (rx_q) begin
                           if (last_q) begin
                              state_q <= ST_STOP;
                           end
                        end else if (sda_s) begin
                           no_ack_flag_q  <= 1'b1;
                           state_q <= ST_STOP;
                        end else if (addr_q && rw_q) begin
                           rx_q <= 1'b1;
                        end else if (ia_left_q != 2'h0) begin
                           addr_q    <= 1'b0;
                           shift_q   <= ia_byte;
                           ia_left_q <= ia_left_q - 1'b1;
                        end else if (!addr_q && read_direction_flag_i) begin
                           state_q   <= ST_START;
                           restart_q <= 1'b1;
                        end else begin
                           state_q <= ST_STOP;
                        end
                     end
                  end
               end
               ST_STOP: begin
                  if (go) begin
                     cnt_q <= HALF_CYC;
                     if (ph_q == 2'h2) begin
                        state_q     <= ST_IDLE;
                        ph_q        <= 2'h0;
                        stop_pend_q <= stop_i;
                        transfer_complete_flag_q    <= ~start_i & ~start_pend_q;
                     end else begin
                        ph_q <= ph_q + 1'b1;
                     end
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
         if (start_i) begin
            transfer_complete_flag_q <= 1'b0;
         end
      end
   end

   twm_fifo #(
      .WIDTH (`TWM_DATA_W),
      .DEPTH (`TWM_FIFO_DEPTH),
      .AW    (`TWM_FIFO_AW)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (push_q),
      .in_ready_o  (fifo_ready),
      .in_data_i   (shift_q),
      .out_valid_o (fifo_valid),
      .out_ready_i (~rhr_full_q | rhr_read_i),
      .out_data_o  (fifo_data)
   );
   assign fifo_pop = fifo_valid & (~rhr_full_q | rhr_read_i);

   // holding register, new byte wins over a same-cycle read
   always @(posedge clk_i) begin
      if (rst_i) begin
         rhr_q      <= 8'h00;
         rhr_full_q <= 1'b0;
         dreq_q     <= 1'b0;
         irq_q      <= 1'b0;
         sack_q     <= 1'b0;
      end else begin
         if (fifo_pop) begin
            rhr_q      <= fifo_data;
            rhr_full_q <= 1'b1;
         end else if (rhr_read_i) begin
            rhr_full_q <= 1'b0;
         end
         dreq_q <= dma_rx_enable_i & (fifo_pop | (rhr_full_q & ~rhr_read_i));
         irq_q  <= arb_irq_enable_i & (arb_q | arb_hit);
         // own-address ack held off after a loss until a status read clears the flag
         sack_q <= slave_role_on_i & ~arb_q & ~arb_hit;
      end
   end

   assign scl_o                      = 1'b0;
   assign sda_o                      = 1'b0;
   assign scl_oe_o                   = scl_oe_q;
   assign sda_oe_o                   = sda_oe_q;
   assign receive_holding_register_o = rhr_q;
   assign receive_holding_full_o     = rhr_full_q;
   assign dma_rx_req_o               = dreq_q;
   assign no_ack_flag_o              = no_ack_flag_q;
   assign arbitration_lost_flag_o    = arb_q;
   assign transfer_complete_flag_o   = transfer_complete_flag_q;
   assign arb_irq_o                  = irq_q;
   assign slave_ack_allow_o          = sack_q;
endmodule

// ### sim/twm_slave_model.sv
/*
 behavioural slave device on the two-wire bus.
 assumes resolved line levels with pull-ups; answers reads with data_i, +11h per byte.
*/
`timescale 1ns/10ps
module twm_slave_model (
   input  wire       scl_i,
   input  wire       sda_i,
   input  wire [6:0] addr_i,
   input  wire [7:0] data_i,
   output reg        sda_oe_o
);
   integer   b = 9;
   integer   n = 0;
   reg [7:0] sh = 8'h00;
   reg [7:0] tx_q = 8'h00;
   reg [7:0] log_q [0:63];
   reg       ack_q [0:63];
   reg       adr_q = 1'h0;
   reg       act_q = 1'h0;
   reg       rd_q = 1'h0;
   initial sda_oe_o = 1'h0;
   always @(negedge sda_i) if (scl_i) begin
      b = -1;
      adr_q = 1'h1;
      act_q = 1'h0;
   end
   always @(posedge sda_i) if (scl_i) begin
      b = 9;
      act_q = 1'h0;
      sda_oe_o = 1'h0;
   end
   always @(posedge scl_i) begin
      if (b >= 0 && b < 8)
         sh = {sh[6:0], sda_i};
      if (b == 8) begin
         log_q[n] = sh;
         ack_q[n] = sda_i;
         n = n + 1;
         if (!adr_q && rd_q && sda_i)
            act_q = 1'h0;
      end
   end
   always @(negedge scl_i) if (b < 9) begin
      if (b == 8 && !adr_q)
         tx_q = tx_q + 8'h11;
      if (b == 8)
         adr_q = 1'h0;
      b = (b == 8) ? 0 : b + 1;
      sda_oe_o = 1'h0;
      if (b == 8 && adr_q) begin
         act_q = (sh[7:1] == addr_i);
         rd_q = sh[0];
         tx_q = data_i;
         sda_oe_o = act_q;
      end else if (b == 8)
         sda_oe_o = act_q && !rd_q;
      else if (act_q && rd_q && !adr_q)
         sda_oe_o = !tx_q[7-b];
   end
endmodule

// ### sim/twm_properties.sv
/*
 port checker for the two-wire master.
 assumes binding to twm_master; raw line levels on scl_i and sda_i.
*/
`timescale 1ns/10ps
module twm_properties (
   input wire clk_i, rst_i, scl_i, scl_oe_o, sda_i, sda_oe_o, master_role_on_i,
   input wire slave_role_on_i, rhr_read_i, status_read_i, dma_rx_enable_i,
   input wire arb_irq_enable_i, receive_holding_full_o, dma_rx_req_o, no_ack_flag_o,
   input wire arbitration_lost_flag_o, transfer_complete_flag_o, arb_irq_o,
   input wire slave_ack_allow_o
);
   reg ext_busy_q;
   always @(posedge clk_i)
      if (rst_i)
         ext_busy_q <= 1'h0;
      else if ($fell(sda_i) && scl_i && !sda_oe_o)
         ext_busy_q <= 1'h1;
      else if ($rose(sda_i) && scl_i)
         ext_busy_q <= 1'h0;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_dma_req;
      dma_rx_req_o == ($past(dma_rx_enable_i) && receive_holding_full_o);
   endproperty
   a_dma_req: assert property (p_dma_req)
      else $error("dma request missing");
   property p_irq;
      !$past(rst_i) && $stable(arb_irq_enable_i && arbitration_lost_flag_o)
      |-> arb_irq_o == (arb_irq_enable_i && arbitration_lost_flag_o);
   endproperty
   a_irq: assert property (p_irq)
      else $error("arbitration interrupt wrong");
   property p_sack;
      !$past(rst_i) && $stable(slave_role_on_i && !arbitration_lost_flag_o)
      |-> slave_ack_allow_o == (slave_role_on_i && !arbitration_lost_flag_o);
   endproperty
   a_sack: assert property (p_sack)
      else $error("own address ack allowed wrongly");
   property p_full;
      receive_holding_full_o && !rhr_read_i |=> receive_holding_full_o;
   endproperty
   a_full: assert property (p_full)
      else $error("holding full dropped without read");
   property p_no_ack_flag;
      no_ack_flag_o && !status_read_i |=> no_ack_flag_o;
   endproperty
   a_no_ack_flag: assert property (p_no_ack_flag)
      else $error("no-ack flag lost");
   property p_arb_rel;
      $rose(arbitration_lost_flag_o) |-> ##[0:1] (!sda_oe_o && !scl_oe_o) [*8];
   endproperty
   a_arb_rel: assert property (p_arb_rel)
      else $error("lines still driven after loss");
   property p_arb_cmp;
      $rose(arbitration_lost_flag_o) |-> ##[0:2] transfer_complete_flag_o;
   endproperty
   a_arb_cmp: assert property (p_arb_cmp)
      else $error("transfer not abandoned");
   property p_stop;
      $fell(sda_oe_o) && scl_i && !scl_oe_o |-> ##[0:60] transfer_complete_flag_o;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop without completion");
   property p_start_en;
      $rose(sda_oe_o) && scl_i && !scl_oe_o |-> master_role_on_i;
   endproperty
   a_start_en: assert property (p_start_en)
      else $error("start while master off");
   property p_busy;
      ext_busy_q |-> !$rose(sda_oe_o);
   endproperty
   a_busy: assert property (p_busy)
      else $error("drove a busy bus");
   c_rx: cover property ($rose(receive_holding_full_o));
   c_arb: cover property ($rose(arbitration_lost_flag_o));
   c_no_ack_flag: cover property ($rose(no_ack_flag_o));
endmodule
bind twm_master twm_properties u_props (.clk_i, .rst_i, .scl_i, .scl_oe_o, .sda_i,
   .sda_oe_o, .master_role_on_i, .slave_role_on_i, .rhr_read_i, .status_read_i,
   .dma_rx_enable_i, .arb_irq_enable_i, .receive_holding_full_o, .dma_rx_req_o,
   .no_ack_flag_o, .arbitration_lost_flag_o, .transfer_complete_flag_o, .arb_irq_o,
   .slave_ack_allow_o);

// ### sim/testbench.sv
/*
 self-checking bench for the two-wire master.
 assumes slave model on the lines; bench pull on data acts as a rival master.
*/
`timescale 1ns/10ps
module testbench;
   reg         clk_i, rst_i, master_role_on_i, slave_role_on_i, start_i, stop_i, tb_pull;
   reg         read_direction_flag_i, rhr_read_i, status_read_i, dma_rx_enable_i;
   reg         arb_irq_enable_i;
   reg  [6:0]  device_address_field_i, slv_addr;
   reg  [1:0]  internal_address_size_i;
   reg  [23:0] internal_address_bytes_i;
   wire [7:0]  receive_holding_register_o;
   wire        scl_o, scl_oe_o, sda_o, sda_oe_o, slv_oe, receive_holding_full_o;
   wire        dma_rx_req_o, no_ack_flag_o, arbitration_lost_flag_o, arb_irq_o;
   wire        transfer_complete_flag_o, slave_ack_allow_o;
   wire        scl_i = !scl_oe_o;
   wire        sda_i = !(sda_oe_o || slv_oe || tb_pull);
   integer     fails = 0;
   integer     n_checks = 0;
   integer     n0, k;
   twm_master uut (.*);
   twm_slave_model slv (.scl_i(scl_i), .sda_i(sda_i), .addr_i(slv_addr),
      .data_i(8'hC3), .sda_oe_o(slv_oe));
   initial begin
      clk_i = 1'h0;
      forever #20 clk_i = ~clk_i;
   end
   task summarize;
      begin
         $display("checks %0d mismatches %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input logic [55:0] got, input logic [55:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   function cond(input integer s);
      case (s)
         0: cond = receive_holding_full_o;
         1: cond = transfer_complete_flag_o;
         2: cond = sda_oe_o;
         default: cond = arbitration_lost_flag_o;
      endcase
   endfunction
   task wait_for(input integer s);
      integer i;
      begin
         i = 0;
         while (cond(s) !== 1'h1 && i < 20000) begin
            @(negedge clk_i);
            i = i + 1;
         end
         if (i == 20000) begin
            fails = fails + 1;
            $display("timeout on wait %0d", s);
            summarize;
         end
      end
   endtask
   task cmd(input [6:0] a, input [1:0] sz, input [23:0] ia, input sp);
      begin
         device_address_field_i = a;
         internal_address_size_i = sz;
         internal_address_bytes_i = ia;
         n0 = slv.n;
         start_i = 1'h1;
         stop_i = sp;
         @(negedge clk_i);
         start_i = 1'h0;
         stop_i = 1'h0;
      end
   endtask
   task pulse_read(input st);
      begin
         rhr_read_i = !st;
         status_read_i = st;
         @(negedge clk_i);
         rhr_read_i = 1'h0;
         status_read_i = 1'h0;
         repeat (3) @(negedge clk_i);
      end
   endtask
   task t_single;
      begin
         master_role_on_i = 1'h0;
         cmd(7'h2C, 2'h0, 24'h0, 1'h1);
         repeat (150) @(negedge clk_i);
         chk({sda_oe_o, scl_oe_o, transfer_complete_flag_o}, 3'h0);
         master_role_on_i = 1'h1;
         wait_for(0);
         chk(receive_holding_register_o, 8'hC3);
         repeat (3) @(negedge clk_i);
         chk(dma_rx_req_o, 1'h1);
         wait_for(1);
         chk(slv.log_q[n0], {7'h2C, 1'h1});
         chk(slv.ack_q[n0+1], 1'h1);
         chk(no_ack_flag_o, 1'h0);
         pulse_read(1'h0);
         chk(receive_holding_full_o, 1'h0);
         $display("single byte read done");
      end
   endtask
   task t_multi;
      logic [55:0] x;
      begin
         x = {7'h2C, 1'h0, 24'h123456, 7'h2C, 1'h1, 8'hC3, 8'hD4};
         dma_rx_enable_i = 1'h0;
         cmd(7'h2C, 2'h3, 24'h123456, 1'h0);
         wait_for(0);
         stop_i = 1'h1;
         @(negedge clk_i);
         stop_i = 1'h0;
         chk(dma_rx_req_o, 1'h0);
         pulse_read(1'h0);
         wait_for(0);
         chk(receive_holding_register_o, 8'hD4);
         pulse_read(1'h0);
         wait_for(1);
         for (k = 0; k < 7; k = k + 1)
            chk(slv.log_q[n0+k], x[55-8*k -: 8]);
         chk({slv.ack_q[n0+5], slv.ack_q[n0+6]}, 2'h1);
         dma_rx_enable_i = 1'h1;
         $display("internal address read done");
      end
   endtask
   task t_ten_no_ack_flag;
      begin
         slv_addr = 7'h7B;
         cmd(7'h7B, 2'h1, 24'hA9B85A, 1'h1);
         wait_for(0);
         wait_for(1);
         chk({slv.log_q[n0], slv.log_q[n0+1], slv.log_q[n0+2]}, 24'hF65AF7);
         pulse_read(1'h0);
         cmd(7'h2D, 2'h0, 24'h0, 1'h1);
         wait_for(1);
         chk(no_ack_flag_o, 1'h1);
         pulse_read(1'h1);
         chk(no_ack_flag_o, 1'h0);
         slv_addr = 7'h2C;
         read_direction_flag_i = 1'h0;
         cmd(7'h2C, 2'h1, 24'h77, 1'h1);
         wait_for(1);
         chk({slv.log_q[n0], slv.log_q[n0+1], receive_holding_full_o}, 17'h0B0EE);
         read_direction_flag_i = 1'h1;
         $display("ten-bit and no-ack done");
      end
   endtask
   task t_arb_busy;
      begin
         wait_for(1);
         slave_role_on_i = 1'h1;
         arb_irq_enable_i = 1'h1;
         cmd(7'h50, 2'h0, 24'h0, 1'h1);
         wait_for(2);
         tb_pull = 1'h1;
         wait_for(3);
         repeat (4) @(negedge clk_i);
         chk({arb_irq_o, slave_ack_allow_o}, 2'h2);
         chk({transfer_complete_flag_o, sda_oe_o, scl_oe_o}, 3'h4);
         tb_pull = 1'h0;
         pulse_read(1'h1);
         chk(slave_ack_allow_o, 1'h1);
         tb_pull = 1'h1;
         repeat (10) @(negedge clk_i);
         cmd(7'h2C, 2'h0, 24'h0, 1'h1);
         repeat (400) @(negedge clk_i);
         chk({sda_oe_o, arbitration_lost_flag_o, transfer_complete_flag_o}, 3'h0);
         tb_pull = 1'h0;
         wait_for(2);
         wait_for(0);
         chk(receive_holding_register_o, 8'hC3);
         pulse_read(1'h0);
         wait_for(1);
         $display("arbitration and busy bus done");
      end
   endtask
   initial begin
      rst_i = 1'h1;
      {start_i, stop_i, rhr_read_i, status_read_i, tb_pull} = 5'h00;
      {slave_role_on_i, arb_irq_enable_i} = 2'h0;
      {master_role_on_i, dma_rx_enable_i, read_direction_flag_i} = 3'h7;
      device_address_field_i = 7'h2C;
      slv_addr = 7'h2C;
      internal_address_size_i = 2'h0;
      internal_address_bytes_i = 24'h0;
      repeat (8) @(negedge clk_i);
      rst_i = 1'h0;
      repeat (4) @(negedge clk_i);
      chk({transfer_complete_flag_o, receive_holding_full_o, scl_o, sda_o,
         scl_oe_o, sda_oe_o}, 6'h20);
      t_single;
      t_multi;
      t_ten_no_ack_flag;
      t_arb_busy;
      summarize;
   end
endmodule
